/* logic/fnp_pkg.sv */
package fnp_pkg;
    // serial write addresses (6 bit)
    localparam logic [5:0] FNP_ADDR_PRESET_A = 6'h05;
    localparam logic [5:0] FNP_ADDR_PRESET_B = 6'h06;
    localparam logic [5:0] FNP_ADDR_PRESET_C = 6'h07;
    localparam logic [5:0] FNP_ADDR_CTRL     = 6'h08;
    localparam logic [5:0] FNP_ADDR_COARSE   = 6'h09;
    localparam logic [5:0] FNP_ADDR_FINE     = 6'h0A;
    localparam int         FNP_WORD_W        = 18;
    localparam int         FNP_GROUPS        = 4;
    // control word field positions
    localparam int FNP_POS_LOOP_EN   = 0;
    localparam int FNP_POS_TUNE_CON  = 2;
    localparam int FNP_POS_OSC_SEL   = 3;
    localparam int FNP_POS_GROUP     = 5;
    localparam int FNP_POS_RC_TRIM_ENABLE     = 7;
    localparam int FNP_POS_BYPASS    = 8;
    localparam int FNP_POS_PUMP      = 9;
    localparam int FNP_POS_GAIN_EN   = 10;
    localparam int FNP_POS_BASE      = 11;
    localparam logic [17:0] FNP_CTRL_RESET = 18'h00484;
    localparam logic [17:0] FNP_WORD_RESET = 18'h00000;
    localparam logic [1:0] FNP_OSC_EXT  = 2'h0;
    localparam logic [1:0] FNP_OSC_LOW  = 2'h2;
    localparam logic [1:0] FNP_OSC_HIGH = 2'h3;
    // timing
    localparam int FNP_CLK_MHZ      = 50;
    localparam int FNP_RC_TIME_US   = 20;
    localparam int FNP_GAIN_TIME_US = 20;
    localparam int FNP_RC_CYC   = FNP_RC_TIME_US * FNP_CLK_MHZ;
    localparam int FNP_GAIN_CYC = FNP_GAIN_TIME_US * FNP_CLK_MHZ;
    localparam int FNP_LOCK_CYC = 8;
    // base frequency in units of 5 kHz: 832 MHz and 1664 MHz
    localparam logic [19:0] FNP_BASE_MID  = 20'h28A00;
    localparam logic [19:0] FNP_BASE_HIGH = 20'h51400;

    typedef struct packed {
        logic        valid;
        logic [5:0]  addr;
        logic [17:0] data;
    } fnp_write_t;

    typedef struct packed {
        logic       loop_on;
        logic       ext_feedback;
        logic       low_band_osc;
        logic       high_band_osc;
        logic       tune_filter_on;
        logic       pump_direct;
        logic       pump_high;
        logic       rc_trim_busy;
        logic       gain_trim_busy;
    } fnp_analog_t;

    typedef enum logic [1:0] {
        FNP_IDLE = 2'b00,
        FNP_RC   = 2'b01,
        FNP_WAIT = 2'b11,
        FNP_GAIN = 2'b10
    } fnp_state_t;
endpackage : fnp_pkg

/* logic/fnp_control.sv */
`timescale 1ns/1ps
module fnp_control
    import fnp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire fnp_write_t  wr,
    input  wire logic        transmit_start_in,
    input  wire logic        transmit_enable_in,
    input  wire logic        receive_enable_in,
    input  wire logic        converter_enable_in,
    input  wire logic        near_lock_in,
    input  wire logic        low_band_rx_in,
    output fnp_analog_t      analog,
    output logic [17:0]      cfg_word_a,
    output logic [17:0]      cfg_word_b,
    output logic [17:0]      cfg_word_c,
    output logic [19:0]      coarse_total,
    output logic [18:0]      fine_step_word,
    output logic             lock_test_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [17:0] ctrl;
    logic [17:0] coarse_freq_word;
    logic [17:0] fine_freq_register;
    logic [17:0] preset [FNP_GROUPS][3];
    logic [3:0]  lock_cnt;
    logic [10:0] timer;
    fnp_state_t  state;
    fnp_state_t  next_state;
    logic        loop_was_on;

    wire logic [1:0] loop_enable_field   = ctrl[FNP_POS_LOOP_EN +: 2];
    wire logic       tune_pin_connect    = ctrl[FNP_POS_TUNE_CON];
    wire logic [1:0] oscillator_select   = ctrl[FNP_POS_OSC_SEL +: 2];
    wire logic [1:0] preset_group_select = ctrl[FNP_POS_GROUP +: 2];
    wire logic       rc_trim_enable      = ctrl[FNP_POS_RC_TRIM_ENABLE];
    wire logic       filter_bypass       = ctrl[FNP_POS_BYPASS];
    wire logic       pump_current_select = ctrl[FNP_POS_PUMP];
    wire logic       gain_trim_enable    = ctrl[FNP_POS_GAIN_EN];
    wire logic [1:0] base_freq_select    = ctrl[FNP_POS_BASE +: 2];

    wire logic loop_on = transmit_start_in | transmit_enable_in | receive_enable_in
                         | (loop_enable_field != 2'h0);
    wire logic trim_start = (loop_on | converter_enable_in) & ~loop_was_on;
    wire logic locked     = lock_cnt == 4'(FNP_LOCK_CYC);

    ////////////////////////////////////////////////////////////////////////
    // control, coarse and fine write steering
    wire logic wr_ctrl   = wr.valid && wr.addr == FNP_ADDR_CTRL;
    wire logic wr_coarse = wr.valid && wr.addr == FNP_ADDR_COARSE;
    wire logic wr_fine   = wr.valid && wr.addr == FNP_ADDR_FINE;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl               <= FNP_CTRL_RESET;
            coarse_freq_word   <= FNP_WORD_RESET;
            fine_freq_register <= FNP_WORD_RESET;
        end else begin
            if (wr_ctrl) ctrl <= wr.data;
            if (wr_coarse) coarse_freq_word <= wr.data;
            if (wr_fine) fine_freq_register <= wr.data;
        end
    end

    // four groups, only addressed word changes
    genvar g;
    for (g = 0; g < FNP_GROUPS; g++) begin : g_grp
        wire logic grp_hit = wr.valid && preset_group_select == 2'(g);
        always_ff @(posedge clk) begin
            if (rst) begin
                preset[g][0] <= FNP_WORD_RESET;
                preset[g][1] <= FNP_WORD_RESET;
                preset[g][2] <= FNP_WORD_RESET;
            end else if (grp_hit) begin
                if (wr.addr == FNP_ADDR_PRESET_A) preset[g][0] <= wr.data;
                if (wr.addr == FNP_ADDR_PRESET_B) preset[g][1] <= wr.data;
                if (wr.addr == FNP_ADDR_PRESET_C) preset[g][2] <= wr.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock filter
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_cnt <= 4'h0;
        end else if (!near_lock_in || !loop_on) begin
            lock_cnt <= 4'h0;
        end else if (!locked) begin
            lock_cnt <= lock_cnt + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration sequencer
    always_comb begin
        next_state = state;
        case (state)
            FNP_IDLE: begin
                if (trim_start && rc_trim_enable) next_state = FNP_RC;
                else if (trim_start) next_state = FNP_WAIT;
            end
            FNP_RC: begin
                if (timer == 11'(FNP_RC_CYC - 1)) next_state = FNP_WAIT;
            end
            FNP_WAIT: begin
                if (!loop_on) next_state = FNP_IDLE;
                else if (locked && gain_trim_enable) next_state = FNP_GAIN;
            end
            FNP_GAIN: begin
                if (timer == 11'(FNP_GAIN_CYC - 1)) next_state = FNP_IDLE;
            end
            default: next_state = FNP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state       <= FNP_IDLE;
            timer       <= 11'h000;
            loop_was_on <= 1'b0;
        end else begin
            state       <= next_state;
            loop_was_on <= loop_on | converter_enable_in;
            timer       <= (next_state != state) ? 11'h000 : timer + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // base plus coarse in 5 kHz units
    wire logic [19:0] base_units = (base_freq_select == 2'h0) ? 20'h00000 :
                                   (base_freq_select == 2'h1) ? FNP_BASE_MID : FNP_BASE_HIGH;
    // sign-extend, doubled step count outside low band rx
    wire logic [18:0] fine_ext = {fine_freq_register[17], fine_freq_register};
    wire logic [18:0] fine_scaled = low_band_rx_in ? fine_ext : {fine_freq_register, 1'b0};

    wire logic next_ext_feedback = oscillator_select == FNP_OSC_EXT;
    wire logic next_low_band     = tune_pin_connect && oscillator_select == FNP_OSC_LOW;
    wire logic next_high_band    = tune_pin_connect && oscillator_select == FNP_OSC_HIGH;
    wire logic next_filter_on    = tune_pin_connect && !filter_bypass;
    wire logic next_pump_direct  = tune_pin_connect && filter_bypass;

    fnp_analog_t next_analog;

    assign next_analog.loop_on        = loop_on;
    assign next_analog.ext_feedback   = next_ext_feedback;
    assign next_analog.low_band_osc   = next_low_band;
    assign next_analog.high_band_osc  = next_high_band;
    assign next_analog.tune_filter_on = next_filter_on;
    assign next_analog.pump_direct    = next_pump_direct;
    assign next_analog.pump_high      = pump_current_select;
    // trim busy flags follow the sequencer's next state
    assign next_analog.rc_trim_busy   = next_state == FNP_RC;
    assign next_analog.gain_trim_busy = next_state == FNP_GAIN;

    ////////////////////////////////////////////////////////////////////////
    // active group drives loop
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_word_a <= FNP_WORD_RESET;
            cfg_word_b <= FNP_WORD_RESET;
            cfg_word_c <= FNP_WORD_RESET;
        end else begin
            cfg_word_a <= preset[preset_group_select][0];
            cfg_word_b <= preset[preset_group_select][1];
            cfg_word_c <= preset[preset_group_select][2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            coarse_total   <= 20'h00000;
            fine_step_word <= 19'h00000;
        end else begin
            coarse_total   <= base_units + {2'h0, coarse_freq_word};
            fine_step_word <= fine_scaled;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_test_out <= 1'b0;
        end else begin
            lock_test_out <= locked;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            analog <= '0;
        end else begin
            analog <= next_analog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_near_run;
        (near_lock_in && loop_on) [*8];
    endsequence

    sequence s_lock_lost;
        !near_lock_in || !loop_on;
    endsequence

    a_lock_after_run: assert property (@(posedge clk) disable iff (rst)
        s_near_run |=> ##1 lock_test_out)
        else $error("lock not shown after locked run");
    a_lock_drop: assert property (@(posedge clk) disable iff (rst)
        s_lock_lost |=> ##1 !lock_test_out)
        else $error("lock stays high when out of lock");
    a_rc_bound: assert property (@(posedge clk) disable iff (rst)
        $rose(analog.rc_trim_busy) |-> ##[1:1000] !analog.rc_trim_busy)
        else $error("rc trim overran");
    a_loop_sources: assert property (@(posedge clk) disable iff (rst)
        (transmit_start_in || receive_enable_in) |=> analog.loop_on)
        else $error("loop not enabled by pin");
    a_ext_osc: assert property (@(posedge clk) disable iff (rst)
        oscillator_select == 2'h0 |=> analog.ext_feedback && !analog.low_band_osc)
        else $error("external feedback not selected");
    a_filter_off: assert property (@(posedge clk) disable iff (rst)
        !tune_pin_connect |=> !analog.tune_filter_on && !analog.pump_direct)
        else $error("filter connected while tune pin off");
    a_group_cfg: assert property (@(posedge clk) disable iff (rst)
        ##1 cfg_word_b == $past(preset[preset_group_select][1]))
        else $error("config not from active group");
    a_pump_cur: assert property (@(posedge clk) disable iff (rst)
        ##1 analog.pump_high == $past(pump_current_select))
        else $error("pump current mismatch");
    a_gain_after_lock: assert property (@(posedge clk) disable iff (rst)
        $rose(analog.gain_trim_busy) |-> $past(locked))
        else $error("gain trim without lock");

    ////////////////////////////////////////////////////////////////////////
    sequence s_trim_begin;
        trim_start && rc_trim_enable && state == FNP_IDLE;
    endsequence

    a_loop_field: assert property (@(posedge clk) disable iff (rst)
        (loop_enable_field != 2'h0) |=> analog.loop_on)
        else $error("loop not enabled by field");

    a_loop_transmit_enable_in: assert property (@(posedge clk) disable iff (rst)
        transmit_enable_in |=> analog.loop_on)
        else $error("loop not enabled by transmit enable");

    a_low_band: assert property (@(posedge clk) disable iff (rst)
        (tune_pin_connect && oscillator_select == 2'h2) |=> analog.low_band_osc)
        else $error("low band oscillator not active");

    a_high_band: assert property (@(posedge clk) disable iff (rst)
        (tune_pin_connect && oscillator_select == 2'h3) |=> analog.high_band_osc
        && !analog.low_band_osc)
        else $error("high band oscillator not active");

    a_filter_on: assert property (@(posedge clk) disable iff (rst)
        (tune_pin_connect && !filter_bypass) |=> analog.tune_filter_on)
        else $error("internal filter not connected");

    a_bypass_route: assert property (@(posedge clk) disable iff (rst)
        (tune_pin_connect && filter_bypass) |=> analog.pump_direct && !analog.tune_filter_on)
        else $error("pump not routed directly");

    ////////////////////////////////////////////////////////////////////////
    a_group_cfg_a: assert property (@(posedge clk) disable iff (rst)
        ##1 cfg_word_a == $past(preset[preset_group_select][0]))
        else $error("first config word not from active group");

    a_group_cfg_c: assert property (@(posedge clk) disable iff (rst)
        ##1 cfg_word_c == $past(preset[preset_group_select][2]))
        else $error("third config word not from active group");

    a_preset_write: assert property (@(posedge clk) disable iff (rst)
        (wr.valid && wr.addr == FNP_ADDR_PRESET_A) |=>
        preset[$past(preset_group_select)][0] == $past(wr.data))
        else $error("preset write missed active group");

    a_preset_keep: assert property (@(posedge clk) disable iff (rst)
        (preset_group_select != 2'h0) |=> preset[0][0] == $past(preset[0][0]))
        else $error("inactive group zero altered");

    a_preset_keep_b: assert property (@(posedge clk) disable iff (rst)
        (preset_group_select != 2'h3) |=> preset[3][1] == $past(preset[3][1]))
        else $error("inactive group three altered");

    ////////////////////////////////////////////////////////////////////////
    a_base_zero: assert property (@(posedge clk) disable iff (rst)
        (base_freq_select == 2'h0) |=> coarse_total == $past({2'h0, coarse_freq_word}))
        else $error("zero base not applied");

    a_base_top: assert property (@(posedge clk) disable iff (rst)
        (base_freq_select == 2'h3) |=>
        coarse_total == $past(FNP_BASE_HIGH + {2'h0, coarse_freq_word}))
        else $error("top base not applied");

    a_fine_sign: assert property (@(posedge clk) disable iff (rst)
        low_band_rx_in |=> fine_step_word[18] == $past(fine_freq_register[17]))
        else $error("fine word sign not extended");

    a_fine_double: assert property (@(posedge clk) disable iff (rst)
        !low_band_rx_in |=> fine_step_word == $past({fine_freq_register, 1'b0}))
        else $error("fine step not doubled");

    ////////////////////////////////////////////////////////////////////////
    a_rc_start: assert property (@(posedge clk) disable iff (rst)
        s_trim_begin |=> analog.rc_trim_busy)
        else $error("rc trim did not start");

    a_lock_needs_loop: assert property (@(posedge clk) disable iff (rst)
        !loop_on |=> ##1 !lock_test_out)
        else $error("lock shown with loop off");

    a_gain_bound: assert property (@(posedge clk) disable iff (rst)
        $rose(analog.gain_trim_busy) |-> ##[1:1000] !analog.gain_trim_busy)
        else $error("gain trim overran");
endmodule : fnp_control

/* dv/fnp_host.sv */
`timescale 1ns/1ps
module fnp_host
    import fnp_pkg::*;
(
    input  wire logic clk,
    output fnp_write_t wr
);
    initial begin
        wr = '0;
    end

    task automatic write(input logic [5:0] a, input logic [17:0] d);
        logic [17:0] v;
        v = d;
        if (a == FNP_ADDR_CTRL) begin
            v[FNP_POS_RC_TRIM_ENABLE] = 1'b1;
        end
        @(negedge clk);
        wr = '{valid: 1'b1, addr: a, data: v};
        @(negedge clk);
        // released word shows inverted lines
        wr = '{valid: 1'b0, addr: ~a, data: ~v};
    endtask : write
endmodule : fnp_host

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench
    import fnp_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        ts, te, re, ce, nl, lb;
    fnp_write_t  wr;
    fnp_analog_t an;
    logic [17:0] wa, wb, wc, d;
    logic [19:0] ct;
    logic [18:0] fs;
    logic        lk;
    logic [17:0] pre [4][3];
    logic [17:0] ctl, crs, external_osc_feedback_in;
    int          seed = 41;
    int          miscompares = 0;
    int          total_checks = 0;
    int          n;

    fnp_host u_fnp_host (.clk(clk), .wr(wr));
    fnp_control u_fnp_control (.clk(clk), .rst(rst), .wr(wr), .transmit_start_in(ts),
        .transmit_enable_in(te), .receive_enable_in(re), .converter_enable_in(ce),
        .near_lock_in(nl), .low_band_rx_in(lb), .analog(an), .cfg_word_a(wa),
        .cfg_word_b(wb), .cfg_word_c(wc), .coarse_total(ct), .fine_step_word(fs),
        .lock_test_out(lk));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick

    task automatic wr_reg(input logic [5:0] a, input logic [17:0] v);
        u_fnp_host.write(a, v);
        tick(2);
    endtask : wr_reg

    task automatic set_ctl(input logic [17:0] c);
        ctl = c | 18'h00080;
        wr_reg(FNP_ADDR_CTRL, c);
    endtask : set_ctl

    task automatic check_all;
        fnp_analog_t e;
        e = '0;
        e.loop_on = ts | te | re | (ctl[1:0] != 2'h0);
        e.ext_feedback = (ctl[4:3] == FNP_OSC_EXT);
        e.low_band_osc = ctl[2] & (ctl[4:3] == FNP_OSC_LOW);
        e.high_band_osc = ctl[2] & (ctl[4:3] == FNP_OSC_HIGH);
        e.tune_filter_on = ctl[2] & ~ctl[8];
        e.pump_direct = ctl[2] & ctl[8];
        e.pump_high = ctl[9];
        chk(20'(an[8:2]), 20'(e[8:2]));
        chk(20'(wa), 20'(pre[ctl[6:5]][0]));
        chk(20'(wb), 20'(pre[ctl[6:5]][1]));
        chk(20'(wc), 20'(pre[ctl[6:5]][2]));
        chk(ct, (ctl[12:11] == 2'h0 ? 20'h0 : ctl[12:11] == 2'h1 ? FNP_BASE_MID
            : FNP_BASE_HIGH) + 20'(crs));
        chk(20'(fs), 20'(lb ? {external_osc_feedback_in[17], external_osc_feedback_in} : {external_osc_feedback_in, 1'b0}));
    endtask : check_all

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {ts, te, re, ce, nl, lb} = '0;
        ctl = FNP_CTRL_RESET;
        crs = '0;
        external_osc_feedback_in = '0;
        pre = '{default: '0};
        tick(5);
        chk(20'({an, lk}), 20'h0);
        rst = 1'b0;
        tick(3);
        check_all();
        for (int g = 0; g < 4; g++) begin
            set_ctl(18'h00084 | 18'(g << 5));
            for (int k = 0; k < 3; k++) begin
                d = 18'($random(seed));
                pre[g][k] = d;
                wr_reg(FNP_ADDR_PRESET_A + 6'(k), d);
            end
            // unmapped address must change nothing
            wr_reg(6'h0B, 18'($random(seed)));
        end
        for (int i = 0; i < 16; i++) begin
            {ts, te, re, ce, lb} = 5'($random(seed));
            crs = 18'($random(seed));
            external_osc_feedback_in = 18'($random(seed));
            if (!lb) external_osc_feedback_in = -external_osc_feedback_in;
            wr_reg(FNP_ADDR_COARSE, crs);
            wr_reg(FNP_ADDR_FINE, external_osc_feedback_in);
            d = 18'($random(seed));
            d[4:3] = 2'(i);
            d[12:11] = 2'(i >> 2);
            set_ctl(d);
            tick(1);
            check_all();
        end
        // trims and lock from a quiet loop
        {ts, te, re, ce} = 4'h0;
        set_ctl(18'h00484);
        tick(2100);
        te = 1'b1;
        tick(4);
        chk(20'(an.rc_trim_busy), 20'h1);
        n = 0;
        while (an.rc_trim_busy === 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        chk(20'((n + 4 > FNP_RC_CYC - 4) && (n + 4 < FNP_RC_CYC + 4)), 20'h1);
        nl = 1'b1;
        tick(6);
        chk(20'(lk), 20'h0);
        tick(4);
        chk(20'(lk), 20'h1);
        n = 0;
        while (an.gain_trim_busy !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(20'(an.gain_trim_busy), 20'h1);
        nl = 1'b0;
        tick(3);
        chk(20'(lk), 20'h0);
        end_sim();
    end

    initial begin
        repeat (12000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule : testbench
